// ===== logic/dns_sequencer.sv
`timescale 1ns/1ps
`include "dns_cfg.svh"

module dns_fifo
    import dns_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          full;
        logic          empty;
    } dns_fifo_s;

    dns_fifo_s             q;
    dns_fifo_s             next_q;
    logic [WIDTH-1:0]      mem [DEPTH];
    logic                  push;
    logic                  pop;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
            $error("dns_fifo: DEPTH must be a power of two >= 2");
    end

    assign push      = in_valid && !q.full;
    assign pop       = out_ready && !q.empty;
    assign in_ready  = !q.full;
    assign out_valid = !q.empty;
    assign out_data  = mem[q.rp];

    always_comb begin
        next_q = q;
        if (push)
            next_q.wp = q.wp + 1'b1;
        if (pop)
            next_q.rp = q.rp + 1'b1;
        if (push && !pop)
            next_q.cnt = q.cnt + 1'b1;
        else if (pop && !push)
            next_q.cnt = q.cnt - 1'b1;
        next_q.full  = (next_q.cnt == (AW+1)'(DEPTH));
        next_q.empty = (next_q.cnt == '0);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
        end else if (ce) begin
            q <= next_q;
        end
    end

    // Storage has no reset; empty flag guards it
    always_ff @(posedge clk) begin
        if (ce && push)
            mem[q.wp] <= in_data;
    end
endmodule

module dns_sequencer
    import dns_pkg::*;
#(
    parameter int NUM_BANKS  = 2,
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [7:0]  dram_timing_register,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [1:0]  req_bank,
    input  wire logic [27:0] req_addr,
    input  wire logic        req_read,
    input  wire logic [1:0]  req_size,
    input  wire logic [1:0]  req_port,
    input  wire logic [31:0] req_wdata,
    output logic             transfer_start_strobe,
    output logic             dram_read_write_indicator,
    output logic [1:0]       transfer_size_code,
    output logic [18:0]      dram_addr,
    output logic             ras_n,
    output logic [3:0]       cas_n,
    output logic             internal_transfer_ack,
    input  wire logic [31:0] dq_in,
    output logic [31:0]      dq_out,
    output logic             dq_oe,
    output logic [31:0]      rd_data,
    output logic             rd_valid
);
    typedef struct packed {
        dns_state_e  state;
        logic        ts;
        logic        rw;
        logic [1:0]  size;
        logic [18:0] pins;
        logic        ras_req;
        logic        cas_req;
        logic [3:0]  lanes;
        logic        ack;
        logic        oe;
        logic [31:0] wdat;
        logic [31:0] rdat;
        logic        rvld;
        logic [27:0] seg_addr;
        logic [4:0]  segs_left;
        logic [1:0]  port;
        logic [1:0]  bank;
        logic [3:0]  wcnt;
        logic [3:0][4:0] pcnt;
    } dns_seq_s;

    dns_seq_s          q;
    dns_seq_s          next_q;
    logic              ras_low;
    logic              cas_low;
    dns_req_s          fin;
    dns_req_s          fout;
    logic              f_valid;
    logic              f_ready;
    logic [3:0]        tim_pre;
    logic [3:0]        tim_cas;
    logic              bank_free;

    initial begin
        if (NUM_BANKS < 1 || NUM_BANKS > 4)
            $error("dns_sequencer: NUM_BANKS must be 1 to 4");
    end

    function automatic logic [4:0] unit_bytes(input logic [1:0] p);
        case (p)
            `DNS_PORT_8:  unit_bytes = 5'h01;
            `DNS_PORT_16: unit_bytes = 5'h02;
            default:      unit_bytes = 5'h04;
        endcase
    endfunction

    function automatic logic [4:0] op_bytes(input logic [1:0] s);
        case (s)
            `DNS_SIZE_BYTE: op_bytes = 5'h01;
            `DNS_SIZE_WORD: op_bytes = 5'h02;
            `DNS_SIZE_LINE: op_bytes = 5'h10;
            default:        op_bytes = 5'h04;
        endcase
    endfunction

    // Lane 0 carries the most significant byte of the data bus
    function automatic logic [3:0] lane_mask(input logic [1:0] p,
                                             input logic [1:0] s,
                                             input logic [1:0] a);
        if (p == `DNS_PORT_8)
            lane_mask = 4'h1;
        else if (p == `DNS_PORT_16)
            lane_mask = 4'h3;
        else if (s == `DNS_SIZE_BYTE)
            lane_mask = 4'h1 << a;
        else if (s == `DNS_SIZE_WORD)
            lane_mask = a[1] ? 4'hc : 4'h3;
        else
            lane_mask = 4'hf;
    endfunction

    assign fin = '{bank: req_bank, addr: req_addr, rw: req_read,
                   size: req_size, port: req_port, wdata: req_wdata};
    assign tim_pre = dram_timing_register[`DNS_TIM_PRE_LSB +: 4];
    assign tim_cas = dram_timing_register[`DNS_TIM_CAS_LSB +: 4];
    // Only the bank being opened is checked; others stay precharged
    assign bank_free = (q.pcnt[fout.bank] == 5'h00);
    assign f_ready   = (q.state == DNS_IDLE) && bank_free;

    dns_fifo #(
        .WIDTH ($bits(dns_req_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .ce        (ce),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   (fin),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (fout)
    );

    always_comb begin
        next_q      = q;
        next_q.rvld = 1'b0;
        for (int b = 0; b < 4; b++) begin
            if (q.pcnt[b] != 5'h00)
                next_q.pcnt[b] = q.pcnt[b] - 5'h01;
        end
        case (q.state)
            DNS_IDLE: begin
                if (f_valid && bank_free) begin
                    next_q.state     = DNS_ROW;
                    next_q.ts        = 1'b1;
                    next_q.rw        = fout.rw;
                    next_q.size      = fout.size;
                    next_q.pins      = fout.addr[27:`DNS_ROW_LSB];
                    next_q.ras_req   = 1'b1;
                    next_q.seg_addr  = fout.addr;
                    next_q.port      = fout.port;
                    next_q.bank      = fout.bank;
                    next_q.wdat      = fout.wdata;
                    next_q.lanes     = lane_mask(fout.port, fout.size,
                                                 fout.addr[1:0]);
                    if (op_bytes(fout.size) > unit_bytes(fout.port))
                        next_q.segs_left = 5'(op_bytes(fout.size)
                                           / unit_bytes(fout.port));
                    else
                        next_q.segs_left = 5'h01;
                end
            end
            DNS_ROW: begin
                next_q.state   = DNS_COL;
                next_q.ts      = 1'b0;
                next_q.pins    = {10'h000, q.seg_addr[`DNS_COL_W-1:0]};
                next_q.cas_req = 1'b1;
                next_q.oe      = !q.rw;
                next_q.wcnt    = tim_cas;
            end
            DNS_COL: begin
                if (q.wcnt == 4'h0) begin
                    next_q.state = DNS_ACK;
                    next_q.ack   = 1'b1;
                end else begin
                    next_q.wcnt = q.wcnt - 4'h1;
                end
            end
            DNS_ACK: begin
                next_q.ack     = 1'b0;
                next_q.ras_req = 1'b0;
                next_q.cas_req = 1'b0;
                next_q.pcnt[q.bank] = `DNS_RP_BASE_CYC + 5'(tim_pre);
                if (q.rw) begin
                    next_q.rdat = dq_in;
                    next_q.rvld = 1'b1;
                end
                if (q.segs_left > 5'h01) begin
                    next_q.state     = DNS_PRE;
                    next_q.segs_left = q.segs_left - 5'h01;
                    next_q.seg_addr  = q.seg_addr
                                       + 28'(unit_bytes(q.port));
                    // next row and next data go out at once
                    next_q.pins = next_q.seg_addr[27:`DNS_ROW_LSB];
                    next_q.wdat = q.wdat << (8 * unit_bytes(q.port));
                end else begin
                    next_q.state = DNS_IDLE;
                    next_q.oe    = 1'b0;
                end
            end
            DNS_PRE: begin
                // One cycle less than a fresh start: RAS opens at L5
                if (q.pcnt[q.bank] <= 5'h01) begin
                    next_q.state   = DNS_ROW;
                    next_q.ras_req = 1'b1;
                end
            end
            default: next_q.state = DNS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q       <= '0;
            q.state <= DNS_IDLE;
            q.rw    <= 1'b1;
        end else if (ce) begin
            q <= next_q;
        end
    end

    // Strobes assert in the low phase but negate on the rising edge
    always_ff @(negedge clk or negedge resetn) begin
        if (!resetn) begin
            ras_low <= 1'b0;
            cas_low <= 1'b0;
        end else if (ce) begin
            ras_low <= q.ras_req;
            cas_low <= q.cas_req;
        end
    end

    assign transfer_start_strobe     = q.ts;
    assign dram_read_write_indicator = q.rw;
    assign transfer_size_code        = q.size;
    assign dram_addr                 = q.pins;
    assign ras_n                     = !(q.ras_req && ras_low);
    assign cas_n     = ~({4{q.cas_req && cas_low}} & q.lanes);
    assign internal_transfer_ack     = q.ack;
    assign dq_out                    = q.wdat;
    assign dq_oe                     = q.oe;
    assign rd_data                   = q.rdat;
    assign rd_valid                  = q.rvld;

    // Checks below assume the clock enable stays high
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn || !ce);

    logic [2:0] since_end;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            since_end <= 3'h7;
        else if (ce && q.state == DNS_ACK)
            since_end <= 3'h0;
        else if (ce && since_end != 3'h7)
            since_end <= since_end + 3'h1;
    end

    wire ts        = q.ts;
    wire ras_req_s = q.ras_req;

    sequence s_open;
        ts && ras_req_s ##1 (!ts && q.cas_req);
    endsequence
    sequence s_close;
        q.ack ##1 (!q.ack && !q.ras_req && !q.cas_req);
    endsequence

    property p_row_col;
        $rose(q.ras_req) |-> q.pins == q.seg_addr[27:9]
            ##1 q.pins[8:0] == q.seg_addr[8:0] && q.cas_req;
    endproperty
    a_row_col: assert property (p_row_col)
        else $error("row then column not presented");

    property p_nonburst;
        (ts && tim_cas == 4'h0) |-> s_open ##1 s_close;
    endproperty
    a_nonburst: assert property (p_nonburst)
        else $error("nonburst transfer not three clocks");

    property p_ts_once;
        ts |=> !ts [*3];
    endproperty
    a_ts_once: assert property (p_ts_once)
        else $error("start strobe repeated within transfer");

    property p_spacing;
        $rose(ts) && q.bank == $past(q.bank) |-> since_end >= 3'h2;
    endproperty
    a_spacing: assert property (p_spacing)
        else $error("same-bank transfer started too early");

    // Short precharge settings leave the other bank idle long enough
    property p_other_bank;
        (q.state == DNS_IDLE && f_valid && fout.bank != q.bank
            && tim_pre <= 4'h3) |=> ts;
    endproperty
    a_other_bank: assert property (p_other_bank)
        else $error("free bank start was delayed");

    property p_secondary;
        (q.state == DNS_ACK && q.segs_left > 5'h01 && tim_pre == 4'h0)
            |=> !q.ras_req ##1 (q.ras_req && !ts) ##1 q.cas_req;
    endproperty
    a_secondary: assert property (p_secondary)
        else $error("secondary segment not four clocks");

    property p_lanes16;
        (q.cas_req && q.port == `DNS_PORT_16) |-> q.lanes == 4'h3;
    endproperty
    a_lanes16: assert property (p_lanes16)
        else $error("sixteen-bit port lanes wrong");

    property p_release;
        (q.ack && q.segs_left == 5'h01) |=> !dq_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("data bus not released after transfer");

    property p_read_capture;
        (q.ack && q.rw) |=> rd_valid && rd_data == $past(dq_in);
    endproperty
    a_read_capture: assert property (p_read_capture)
        else $error("read data not captured after ack");
endmodule

// ===== logic/dns_cfg.svh
// Notes on behaviour
// - Fresh row and column every transfer
// - Row, direction, RAS; then column, CAS
// - Nonburst transfer starts with start strobe
// - Wait bank precharge before new transfer
// - Other bank waits only for its own earlier precharge
// - Reads and writes share strobe timing
// - Nonburst three clocks, 2.5 clock precharge
// - Read first phase: row, high, size
// - Write first phase: row, low, size
// - RAS low phase; column; CAS next
// - Ack one clock early; data next edge
// - Completing edge drops ack, RAS, CAS
// - Next core transfer no earlier than fifth
// - Oversized operand becomes segmented burst
// - Start strobe once per transfer
// - Secondary segment waits for precharge
// - Burst three clocks, then four each
// - Between segments new row, RAS reopened
// - Sixteen-bit port: upper half, two lanes
// - Burst write end releases data bus
`ifndef DNS_CFG_SVH
`define DNS_CFG_SVH

`define DNS_TIM_PRE_LSB    0
`define DNS_TIM_CAS_LSB    4
`define DNS_TIM_FIELD_W    4

`define DNS_SIZE_LONG      2'h0
`define DNS_SIZE_BYTE      2'h1
`define DNS_SIZE_WORD      2'h2
`define DNS_SIZE_LINE      2'h3

`define DNS_PORT_32        2'h0
`define DNS_PORT_8         2'h1
`define DNS_PORT_16        2'h2

`define DNS_RP_BASE_CYC    5'h01
`define DNS_ROW_LSB        9
`define DNS_COL_W          9
`define DNS_PIN_W          19

`endif

// ===== logic/dns_pkg.sv
package dns_pkg;

    typedef enum logic [2:0] {
        DNS_IDLE = 3'b000,
        DNS_ROW  = 3'b001,
        DNS_COL  = 3'b011,
        DNS_ACK  = 3'b010,
        DNS_PRE  = 3'b110
    } dns_state_e;

    typedef struct packed {
        logic [1:0]  bank;
        logic [27:0] addr;
        logic        rw;
        logic [1:0]  size;
        logic [1:0]  port;
        logic [31:0] wdata;
    } dns_req_s;

endpackage

// ===== verif/dns_dram_model.sv
`timescale 1ns/1ps
module dns_dram_model (
    input  wire logic        ras_n,
    input  wire logic [3:0]  cas_n,
    input  wire logic [18:0] dram_addr,
    input  wire logic        rw,
    input  wire logic [31:0] dq_out,
    input  wire logic        dq_oe,
    output logic      [31:0] dq_in
);
    logic [18:0] row = 19'h0;
    logic [8:0]  col = 9'h0;
    logic [31:0] word;
    logic [31:0] wr_q[$];
    logic [8:0]  col_q[$];
    logic [3:0]  lane_q[$];

    always @(negedge ras_n) row = dram_addr;
    // Any lane falling latches the column and the write data
    always @(negedge (&cas_n)) begin
        col = dram_addr[8:0];
        col_q.push_back(col);
        lane_q.push_back(cas_n);
        if (!rw && dq_oe) wr_q.push_back(dq_out);
    end
    // Top byte carries the column, so a narrow port reads it on lane 0
    assign word  = {col[7:0], ~col[7:0], row[7:0], 8'h3c};
    // No pull-up: a released bus shows the inverse, never a stale copy
    assign dq_in = (rw && !(&cas_n)) ? word : ~word;
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`include "dns_cfg.svh"
module tb_top;
    logic        clk, resetn, ce, req_valid, req_ready, req_read;
    logic        ts, rw, ras_n, ack, dq_oe, rd_valid;
    logic [1:0]  req_bank, req_size, req_port, size;
    logic [27:0] req_addr;
    logic [31:0] req_wdata, dq_in, dq_out, rd_data;
    logic [18:0] dram_addr;
    logic [3:0]  cas_n;
    logic [7:0]  tim;
    int          num_errors, checks_done, cyc, ts_q[$], ack_q[$];
    bit          saw_full;

    dns_sequencer #(.NUM_BANKS(2), .FIFO_DEPTH(4)) dns_sequencer_i (
        .clk(clk), .resetn(resetn), .ce(ce),
        .dram_timing_register(tim), .req_valid(req_valid),
        .req_ready(req_ready), .req_bank(req_bank), .req_addr(req_addr),
        .req_read(req_read), .req_size(req_size), .req_port(req_port),
        .req_wdata(req_wdata), .transfer_start_strobe(ts),
        .dram_read_write_indicator(rw), .transfer_size_code(size),
        .dram_addr(dram_addr), .ras_n(ras_n), .cas_n(cas_n),
        .internal_transfer_ack(ack), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .rd_data(rd_data), .rd_valid(rd_valid)
    );
    dns_dram_model dns_dram_model_i (
        .ras_n(ras_n), .cas_n(cas_n), .dram_addr(dram_addr), .rw(rw),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // Sampled mid-cycle so registered outputs have settled
    always @(negedge clk) begin
        if (ts === 1'b1) ts_q.push_back(cyc);
        if (ack === 1'b1) ack_q.push_back(cyc);
        if (req_ready === 1'b0) saw_full = 1'b1;
    end

    task give_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        chk_val(32'(got), 32'(exp));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic start;
        tick(12);
        ts_q.delete();
        ack_q.delete();
        dns_dram_model_i.wr_q.delete();
        dns_dram_model_i.col_q.delete();
        dns_dram_model_i.lane_q.delete();
    endtask
    // Holds the request until the registered ready is seen high
    task automatic push(input logic [1:0] b, input logic [27:0] a,
                        input logic r, input logic [1:0] s,
                        input logic [1:0] p, input logic [31:0] w);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_bank = b;
        req_addr = a;
        req_read = r;
        req_size = s;
        req_port = p;
        req_wdata = w;
        while (req_ready !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        if (n == 100) begin
            num_errors++;
            give_verdict;
        end
        tick(1);
    endtask
    task automatic await_ts;
        int n;
        n = 0;
        req_valid = 1'b0;
        while (ts !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        if (n == 50) begin
            num_errors++;
            give_verdict;
        end
    endtask
    task automatic wait_ts(input int k);
        int n;
        n = 0;
        while (ts_q.size() < k && n < 300) begin
            tick(1);
            n++;
        end
        if (n == 300) begin
            num_errors++;
            give_verdict;
        end
        tick(12);
    endtask

    task automatic read_byte;
        logic [27:0] a;
        a = 28'h0abc_d123;
        start;
        push(2'h0, a, 1'b1, `DNS_SIZE_BYTE, `DNS_PORT_8, 32'h0);
        await_ts;
        chk_val(32'(rw), 32'h1);
        chk_val(32'(size), 32'(`DNS_SIZE_BYTE));
        chk_val(32'(dram_addr), 32'(a[27:9]));
        tick(1);
        chk_val({ts, ras_n}, 32'h0);
        chk_val(32'(dram_addr), 32'(a[8:0]));
        @(negedge clk);
        #1;
        chk_val(32'(cas_n), 32'he);
        tick(1);
        chk_val(32'(ack), 32'h1);
        tick(1);
        chk_val({ack, ras_n, cas_n, rd_valid}, 32'h3f);
        chk_val(32'(rd_data[31:24]), 32'h23);
    endtask
    task automatic two_reads(input logic [1:0] b0, input logic [1:0] b1,
                             input int gap, input int lat);
        start;
        push(b0, 28'h0000_1200, 1'b1, `DNS_SIZE_BYTE, `DNS_PORT_8, 32'h0);
        push(b1, 28'h0000_3400, 1'b1, `DNS_SIZE_BYTE, `DNS_PORT_8, 32'h0);
        req_valid = 1'b0;
        wait_ts(2);
        chk_cnt(ts_q[1] - ts_q[0], gap);
        chk_cnt(ack_q[0] - ts_q[0], lat);
    endtask
    task automatic same_bank;
        two_reads(2'h1, 2'h1, 5, 2);
    endtask
    task automatic other_bank;
        two_reads(2'h0, 2'h1, 4, 2);
    endtask
    // Extra precharge and CAS wait both stretch the same-bank spacing
    task automatic slow_timing;
        tim = 8'h32;
        two_reads(2'h0, 2'h0, 10, 5);
        tick(20);
        tim = 8'h00;
    endtask
    task automatic burst_write;
        logic [27:0] a;
        a = 28'h0012_3402;
        start;
        push(2'h0, a, 1'b0, `DNS_SIZE_LONG, `DNS_PORT_16, 32'h1234_5678);
        await_ts;
        chk_val({rw, size}, 32'(`DNS_SIZE_LONG));
        chk_val(32'(dram_addr), 32'(a[27:9]));
        tick(20);
        chk_cnt(ts_q.size(), 1);
        chk_cnt(ack_q.size(), 2);
        chk_cnt(ack_q[0] - ts_q[0], 2);
        chk_cnt(ack_q[1] - ack_q[0], 4);
        chk_val(dns_dram_model_i.wr_q[0][31:16], 32'h1234);
        chk_val(dns_dram_model_i.wr_q[1][31:16], 32'h5678);
        chk_val(32'(dns_dram_model_i.lane_q[1]), 32'hc);
        chk_val(32'(dns_dram_model_i.col_q[1]), 32'h004);
        chk_val(32'(dq_oe), 32'h0);
    endtask
    task automatic fifo_fill;
        start;
        saw_full = 1'b0;
        for (int i = 0; i < 6; i++)
            push(2'h0, 28'(i * 4), 1'b1, `DNS_SIZE_BYTE, `DNS_PORT_32, 32'h0);
        req_valid = 1'b0;
        wait_ts(6);
        chk_cnt(int'(saw_full), 1);
        for (int i = 1; i < 6; i++)
            chk_cnt(ts_q[i] - ts_q[i-1], 5);
    endtask
    // A line read to a full-width port splits into four segments
    task automatic burst_read;
        logic [27:0] a;
        a = 28'h0004_5610;
        start;
        push(2'h0, a, 1'b1, `DNS_SIZE_LINE, `DNS_PORT_32, 32'h0);
        await_ts;
        chk_val(32'({1'b1, `DNS_SIZE_LINE}), 32'({rw, size}));
        tick(30);
        chk_cnt(ts_q.size(), 1);
        chk_cnt(ack_q.size(), 4);
        chk_cnt(ack_q[3] - ack_q[0], 12);
        chk_val(32'(dns_dram_model_i.lane_q[0]), 32'h0);
        chk_val(32'(dns_dram_model_i.col_q[3]), 32'h01c);
        chk_val(rd_data, 32'h1ce3_2b3c);
    endtask
    // A frozen start must resume where it stopped, RAS still closed
    task automatic ce_hold;
        start;
        push(2'h1, 28'h0000_0800, 1'b1, `DNS_SIZE_BYTE, `DNS_PORT_8, 32'h0);
        await_ts;
        ce = 1'b0;
        tick(3);
        chk_val(32'({ts, ras_n}), 32'h3);
        ce = 1'b1;
        tick(6);
        chk_cnt(ack_q.size(), 1);
        chk_cnt(ack_q[0] - ts_q[0], 5);
    endtask

    initial begin
        resetn = 1'b0;
        req_valid = 1'b0;
        req_bank = 2'h0;
        req_addr = 28'h0;
        req_read = 1'b0;
        req_size = 2'h0;
        req_port = 2'h0;
        req_wdata = 32'h0;
        tim = 8'h00;
        ce = 1'b1;
        cyc = 0;
        num_errors = 0;
        checks_done = 0;
        saw_full = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        read_byte;
        same_bank;
        other_bank;
        slow_timing;
        burst_write;
        fifo_fill;
        burst_read;
        ce_hold;
        give_verdict;
    end
endmodule
